// >>> verilog/sbr_baud_gen.sv
// Purpose: Baud rate generator with AHB-Lite register access.
// Assumes: hclk is the oscillator clock; receiver status is synchronous.
// Notes:   Zero-wait slave, always OKAY; unmapped reads give zero.
`timescale 1ns/100ps
module sbr_baud_gen (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic        rx_idle,
  input  wire logic        abd_overflow,
  input  wire logic        rx_frame_err,
  input  wire logic        rx_overrun,
  input  wire logic        tx_shift_empty,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             baud_tick,
  output logic             sync_mode,
  output logic             high_speed_select,
  output logic             wide_divisor_select,
  output logic [7:0]       baud_control,
  output logic [7:0]       receive_status_control,
  output logic [7:0]       transmit_status_control
);

  typedef struct packed {
    logic [7:0]                     baud_ctl;
    logic [7:0]                     rx_ctl;
    logic [7:0]                     tx_ctl;
    logic [15:0]                    divisor;
    sbr_pkg::sbr_phase_e            phase;
    logic [7:0]                     wr_addr;
    logic [sbr_pkg::SBR_POST_W-1:0] post;
    logic                           tick;
    logic [31:0]                    rdata;
    logic                           ready;
  } sbr_top_s;

  localparam sbr_top_s RST = '{
    baud_ctl: sbr_pkg::SBR_BAUD_RST,
    rx_ctl:   sbr_pkg::SBR_RX_RST,
    tx_ctl:   sbr_pkg::SBR_TX_RST,
    divisor:  sbr_pkg::SBR_DIV_RST,
    phase:    sbr_pkg::SBR_DP_IDLE,
    wr_addr:  8'h00,
    post:     '0,
    tick:     1'b0,
    rdata:    32'h0000_0000,
    ready:    1'b1
  };

  sbr_top_s   r;
  sbr_top_s   next_r;
  logic       addr_ok;
  logic       in_write;
  logic       div_wr;
  logic       cfg_wr;
  logic       wrap;
  logic [6:0] mult;
  logic [7:0] rd_byte;
  logic [7:0] wbyte;

  // Live status bits replace the stored ones on reads
  function automatic logic [7:0] read_reg(input sbr_top_s s, input logic [7:0] a,
                                          input logic idle, input logic ovf,
                                          input logic ferr, input logic oerr,
                                          input logic empty);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      sbr_pkg::SBR_OFF_BAUD_CTL: begin
        v = s.baud_ctl & sbr_pkg::SBR_BAUD_WMASK;
        v[sbr_pkg::SBR_B_ABD_OVF] = ovf;
        v[sbr_pkg::SBR_B_RX_IDLE] = idle;
      end
      sbr_pkg::SBR_OFF_RX_CTL: begin
        v = s.rx_ctl & sbr_pkg::SBR_RX_WMASK;
        v[sbr_pkg::SBR_R_FRAME] = ferr;
        v[sbr_pkg::SBR_R_OVRUN] = oerr;
      end
      sbr_pkg::SBR_OFF_DIV_LO: v = s.divisor[7:0];
      sbr_pkg::SBR_OFF_DIV_HI: v = s.divisor[15:8];
      sbr_pkg::SBR_OFF_TX_CTL: begin
        v = s.tx_ctl & sbr_pkg::SBR_TX_WMASK;
        v[sbr_pkg::SBR_T_EMPTY] = empty;
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction : read_reg

  always_comb begin
    next_r = r;
    next_r.tick = 1'b0;
    next_r.ready = 1'b1;
    wbyte = hwdata[7:0];
    addr_ok = hsel && htrans[1] && hready;
    in_write = (r.phase == sbr_pkg::SBR_DP_WRITE);
    div_wr = in_write && ((r.wr_addr == sbr_pkg::SBR_OFF_DIV_LO) ||
                          (r.wr_addr == sbr_pkg::SBR_OFF_DIV_HI));
    cfg_wr = in_write && ((r.wr_addr == sbr_pkg::SBR_OFF_BAUD_CTL) ||
                          (r.wr_addr == sbr_pkg::SBR_OFF_TX_CTL));
    rd_byte = read_reg(r, haddr[7:0], rx_idle, abd_overflow, rx_frame_err,
                       rx_overrun, tx_shift_empty);

    // Write data phase: store the byte lane of the captured register
    case (r.phase)
      sbr_pkg::SBR_DP_WRITE: begin
        case (r.wr_addr)
          sbr_pkg::SBR_OFF_BAUD_CTL:
            next_r.baud_ctl = wbyte & sbr_pkg::SBR_BAUD_WMASK;
          sbr_pkg::SBR_OFF_RX_CTL:
            next_r.rx_ctl = wbyte & sbr_pkg::SBR_RX_WMASK;
          sbr_pkg::SBR_OFF_DIV_LO:
            next_r.divisor[7:0] = wbyte;
          sbr_pkg::SBR_OFF_DIV_HI:
            next_r.divisor[15:8] = wbyte;
          sbr_pkg::SBR_OFF_TX_CTL:
            next_r.tx_ctl = wbyte & sbr_pkg::SBR_TX_WMASK;
          default: next_r.divisor = r.divisor;
        endcase
      end
      sbr_pkg::SBR_DP_READ: next_r.rdata = r.rdata;
      sbr_pkg::SBR_DP_IDLE: next_r.rdata = r.rdata;
      default: next_r.phase = sbr_pkg::SBR_DP_IDLE;
    endcase

    // Address phase; read data is prepared here so it stands in the data phase
    if (addr_ok && hwrite) begin
      next_r.phase = sbr_pkg::SBR_DP_WRITE;
      next_r.wr_addr = haddr[7:0];
    end else if (addr_ok) begin
      next_r.phase = sbr_pkg::SBR_DP_READ;
      next_r.rdata = {24'h000000, rd_byte};
    end else begin
      next_r.phase = sbr_pkg::SBR_DP_IDLE;
    end

    // Multiplier from the current mode bits
    if (r.tx_ctl[sbr_pkg::SBR_T_SYNC]) begin
      mult = sbr_pkg::SBR_MULT_FAST;
    end else if (r.baud_ctl[sbr_pkg::SBR_B_WIDE]) begin
      mult = r.tx_ctl[sbr_pkg::SBR_T_HS] ? sbr_pkg::SBR_MULT_FAST
                                         : sbr_pkg::SBR_MULT_MID;
    end else begin
      mult = r.tx_ctl[sbr_pkg::SBR_T_HS] ? sbr_pkg::SBR_MULT_MID
                                         : sbr_pkg::SBR_MULT_SLOW;
    end

    // Postscaler over timer wraps; a mode change that shrinks the
    // multiplier below the running count ends the period at the next timer wrap
    if (div_wr) begin
      next_r.post = '0;
    end else if (wrap) begin
      if ({1'b0, r.post} >= (mult - 7'h01)) begin
        next_r.post = '0;
        next_r.tick = 1'b1;
      end else begin
        next_r.post = r.post + 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= RST;
    end else begin
      r <= next_r;
    end
  end

  sbr_baud_timer #(
    .DIV_W (16)
  ) u_baud_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .divisor (r.divisor),
    .wide    (r.baud_ctl[sbr_pkg::SBR_B_WIDE]),
    .clear   (div_wr),
    .wrap    (wrap)
  );

  assign hrdata                  = r.rdata;
  assign hreadyout               = r.ready;
  assign hresp                   = 1'b0;
  assign baud_tick               = r.tick;
  assign sync_mode               = r.tx_ctl[sbr_pkg::SBR_T_SYNC];
  assign high_speed_select       = r.tx_ctl[sbr_pkg::SBR_T_HS];
  assign wide_divisor_select     = r.baud_ctl[sbr_pkg::SBR_B_WIDE];
  assign baud_control            = r.baud_ctl;
  assign receive_status_control  = r.rx_ctl;
  assign transmit_status_control = r.tx_ctl;

  // Checker helpers: gap since the last tick, steady-state flag
  logic [22:0] gap;
  logic        clean;
  logic        width_written;
  logic [22:0] eff_n1;

  assign eff_n1 = wide_divisor_select ? (23'(r.divisor) + 23'h1)
                                      : (23'(r.divisor[7:0]) + 23'h1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap <= 23'h0;
      clean <= 1'b0;
      width_written <= 1'b0;
    end else begin
      gap <= baud_tick ? 23'h0 : ((gap == 23'h7fffff) ? gap : gap + 23'h1);
      clean <= (div_wr || cfg_wr) ? 1'b0 : (baud_tick ? 1'b1 : clean);
      if (in_write && (r.wr_addr == sbr_pkg::SBR_OFF_BAUD_CTL)) begin
        width_written <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_div_write;
    div_wr;
  endsequence

  sequence s_tx_write;
    in_write && (r.wr_addr == sbr_pkg::SBR_OFF_TX_CTL);
  endsequence

  property p_clear_now;
    s_div_write |=> (r.post == '0) && !baud_tick ##1 !baud_tick;
  endproperty
  a_clear_now: assert property (p_clear_now)
    else $error("divisor write did not restart the generator");

  property p_narrow_default;
    wide_divisor_select |-> width_written;
  endproperty
  a_narrow_default: assert property (p_narrow_default)
    else $error("16-bit mode without a software write");

  property p_div_low;
    in_write && (r.wr_addr == sbr_pkg::SBR_OFF_DIV_LO) |=>
      (r.divisor[7:0] == $past(hwdata[7:0])) && $stable(r.divisor[15:8]);
  endproperty
  a_div_low: assert property (p_div_low)
    else $error("low divisor byte misplaced");

  property p_tx_bits;
    s_tx_write |=> (sync_mode == $past(hwdata[4])) && (high_speed_select == $past(hwdata[2]));
  endproperty
  a_tx_bits: assert property (p_tx_bits)
    else $error("mode bits not at their positions");

  property p_rate_a8;
    baud_tick && clean && !sync_mode && !wide_divisor_select && !high_speed_select |->
      (gap + 23'h1) == (eff_n1 << 6);
  endproperty
  a_rate_a8: assert property (p_rate_a8)
    else $error("async 8-bit rate wrong");

  property p_rate_a16;
    baud_tick && clean && !sync_mode && wide_divisor_select && !high_speed_select |->
      (gap + 23'h1) == (eff_n1 << 4);
  endproperty
  a_rate_a16: assert property (p_rate_a16)
    else $error("async 16-bit rate wrong");

  property p_rate_s8;
    baud_tick && clean && sync_mode && !wide_divisor_select |-> (gap + 23'h1) == (eff_n1 << 2);
  endproperty
  a_rate_s8: assert property (p_rate_s8)
    else $error("sync 8-bit rate wrong");

  property p_rate_hs;
    baud_tick && clean && !sync_mode && high_speed_select |->
      (gap + 23'h1) == (wide_divisor_select ? (eff_n1 << 2) : (eff_n1 << 4));
  endproperty
  a_rate_hs: assert property (p_rate_hs)
    else $error("high-speed rate wrong");

  property p_sync_hs;
    baud_tick && clean && sync_mode && high_speed_select |-> (gap + 23'h1) == (eff_n1 << 2);
  endproperty
  a_sync_hs: assert property (p_sync_hs)
    else $error("high-speed changed sync rate");

endmodule : sbr_baud_gen

// >>> common/sbr_pkg.sv
// Purpose: Shared constants for the serial baud rate generator.
// Assumes: Word-aligned AHB-Lite register map, one register per word.
// Notes:   Register bytes sit in bits 7:0; upper bits read as zero.
//
// Behaviour
// - Timer is 8-bit after reset; width select set makes it 16-bit.
// - Timer runs freely; period set by the low divisor, or by both divisor registers combined in 16-bit mode.
// - Async multiplier depends on both high-speed and width selects.
// - In synchronous mode the high-speed select has no effect.
// - Writing either divisor register clears the timer at once.
// - Async, 8-bit, high-speed off: rate is clock over 64 times (n+1).
// - Async, 16-bit, high-speed off: rate is clock over 16 times (n+1).
// - Sync, 8-bit: rate is clock over 4 times (n+1), any high-speed.
// - Low divisor holds bits 7..0, high divisor holds bits 15..8.
// - Sync at transmit bit 4, high-speed at bit 2, width at baud bit 3.
package sbr_pkg;

  localparam logic [7:0] SBR_OFF_BAUD_CTL = 8'h00;
  localparam logic [7:0] SBR_OFF_RX_CTL   = 8'h04;
  localparam logic [7:0] SBR_OFF_DIV_LO   = 8'h08;
  localparam logic [7:0] SBR_OFF_DIV_HI   = 8'h0c;
  localparam logic [7:0] SBR_OFF_TX_CTL   = 8'h10;

  // Baud control fields
  localparam int unsigned SBR_B_ABD_OVF = 7;
  localparam int unsigned SBR_B_RX_IDLE = 6;
  localparam int unsigned SBR_B_WIDE    = 3;
  localparam logic [7:0]  SBR_BAUD_WMASK = 8'h1b;
  localparam logic [7:0]  SBR_BAUD_RST   = 8'h00;

  // Transmit status and control fields
  localparam int unsigned SBR_T_SYNC  = 4;
  localparam int unsigned SBR_T_HS    = 2;
  localparam int unsigned SBR_T_EMPTY = 1;
  localparam logic [7:0]  SBR_TX_WMASK = 8'hfd;
  localparam logic [7:0]  SBR_TX_RST   = 8'h00;

  // Receive status and control fields
  localparam int unsigned SBR_R_FRAME = 2;
  localparam int unsigned SBR_R_OVRUN = 1;
  localparam logic [7:0]  SBR_RX_WMASK = 8'hf9;
  localparam logic [7:0]  SBR_RX_RST   = 8'h00;

  localparam logic [15:0] SBR_DIV_RST = 16'h0000;

  // Divide multipliers on top of the (n+1) timer period
  localparam logic [6:0] SBR_MULT_SLOW = 7'h40;
  localparam logic [6:0] SBR_MULT_MID  = 7'h10;
  localparam logic [6:0] SBR_MULT_FAST = 7'h04;
  localparam int unsigned SBR_POST_W = 6;

  // Data-phase tracking of the bus slave
  typedef enum logic [2:0] {
    SBR_DP_IDLE  = 3'b001,
    SBR_DP_WRITE = 3'b010,
    SBR_DP_READ  = 3'b100
  } sbr_phase_e;

endpackage : sbr_pkg

// >>> verilog/sbr_baud_timer.sv
// Purpose: Free-running divisor counter of the baud generator.
// Assumes: Divisor and controls come from logic on the same clock.
// Notes:   Wrap pulse is registered, one cycle per divisor-plus-one counts.
`timescale 1ns/100ps
module sbr_baud_timer #(
  parameter int unsigned DIV_W = 16
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [DIV_W-1:0] divisor,
  input  wire logic             wide,
  input  wire logic             clear,
  output logic                  wrap
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             wrap;
  } sbr_tmr_s;

  sbr_tmr_s         r;
  sbr_tmr_s         next_r;
  logic [DIV_W-1:0] limit;

  always_comb begin
    limit = divisor;
    if (!wide) begin
      limit[DIV_W-1:8] = '0;
    end
    next_r = r;
    next_r.wrap = 1'b0;
    if (clear) begin
      next_r.cnt = '0;
    end else if (r.cnt >= limit) begin
      // Greater-or-equal also recovers when the width shrinks mid-count
      next_r.cnt = '0;
      next_r.wrap = 1'b1;
    end else begin
      next_r.cnt = r.cnt + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign wrap = r.wrap;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_clear_restart;
    clear |=> (r.cnt == '0) && !wrap;
  endproperty
  a_clear_restart: assert property (p_clear_restart)
    else $error("timer not cleared after divisor write");

  property p_narrow_range;
    !wide [*2] |-> (r.cnt[DIV_W-1:8] == '0);
  endproperty
  a_narrow_range: assert property (p_narrow_range)
    else $error("timer exceeds 8 bits in narrow mode");

endmodule : sbr_baud_timer

// >>> verification/sbr_baud_gen_test.sv
// Purpose: Self-checking bench for the baud rate generator and its registers.
// Assumes: Zero-wait AHB-Lite slave; first tick comes p+1 edges after a divisor write ends.
// Notes:   Divisors are kept small so the widest mode stays a few thousand cycles.
`timescale 1ns/100ps
module sbr_baud_gen_test;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        rx_idle;
  logic        abd_overflow;
  logic        rx_frame_err;
  logic        rx_overrun;
  logic        tx_shift_empty;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        baud_tick;
  logic        sync_mode;
  logic        high_speed_select;
  logic        wide_divisor_select;
  logic [7:0]  baud_control;
  logic [7:0]  receive_status_control;
  logic [7:0]  transmit_status_control;
  int          miscompares;
  int          comparisons;

  sbr_baud_gen uut (
    .hclk                    (hclk),
    .hresetn                 (hresetn),
    .hsel                    (hsel),
    .haddr                   (haddr),
    .htrans                  (htrans),
    .hwrite                  (hwrite),
    .hsize                   (hsize),
    .hwdata                  (hwdata),
    .hready                  (hreadyout),
    .rx_idle                 (rx_idle),
    .abd_overflow            (abd_overflow),
    .rx_frame_err            (rx_frame_err),
    .rx_overrun              (rx_overrun),
    .tx_shift_empty          (tx_shift_empty),
    .hrdata                  (hrdata),
    .hreadyout               (hreadyout),
    .hresp                   (hresp),
    .baud_tick               (baud_tick),
    .sync_mode               (sync_mode),
    .high_speed_select       (high_speed_select),
    .wide_divisor_select     (wide_divisor_select),
    .baud_control            (baud_control),
    .receive_status_control  (receive_status_control),
    .transmit_status_control (transmit_status_control)
  );

  always #25 hclk = ~hclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    comparisons++;
    if (seen !== expected) begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, expected);
    end
  endtask : check

  task automatic wrap_up;
    if (miscompares == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // Entered right after a rising edge; returns at the edge ending the data phase
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h000000, addr};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wdata;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdata = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] addr, input logic [31:0] wdata);
    logic [31:0] dummy;
    bus(1'b1, addr, wdata, dummy);
  endtask : wr

  task automatic rd(input logic [7:0] addr, input logic [31:0] expected);
    logic [31:0] got;
    bus(1'b0, addr, 32'h00000000, got);
    check(got, expected);
  endtask : rd

  task automatic run_case(input logic sync, input logic hs, input logic wide, input logic [7:0] hi,
                          input logic [7:0] lo);
    int mult;
    int p;
    mult = sync ? 4 : (wide ? (hs ? 4 : 16) : (hs ? 16 : 64));
    p = mult * ((wide ? int'({hi, lo}) : int'(lo)) + 1);
    wr(sbr_pkg::SBR_OFF_TX_CTL, {24'h000000, 3'b000, sync, 1'b0, hs, 2'b00});
    wr(sbr_pkg::SBR_OFF_BAUD_CTL, {24'h000000, 4'h0, wide, 3'b000});
    wr(sbr_pkg::SBR_OFF_DIV_HI, {24'h000000, hi});
    // Width output only settles after its write edge, so look one write later
    check(wide_divisor_select, wide);
    // Low byte written last, so its clear sets the reference point
    wr(sbr_pkg::SBR_OFF_DIV_LO, {24'h000000, lo});
    repeat (p) @(posedge hclk);
    #1 check(baud_tick, 1'b0);
    @(posedge hclk);
    #1 check(baud_tick, 1'b1);
    repeat (p - 1) @(posedge hclk);
    #1 check(baud_tick, 1'b0);
    @(posedge hclk);
    #1 check(baud_tick, 1'b1);
  endtask : run_case

  initial begin
    repeat (40000) @(posedge hclk);
    miscompares++;
    wrap_up();
  end

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    rx_idle = 1'b0;
    abd_overflow = 1'b0;
    rx_frame_err = 1'b0;
    rx_overrun = 1'b0;
    tx_shift_empty = 1'b0;
    miscompares = 0;
    comparisons = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(sbr_pkg::SBR_OFF_BAUD_CTL, 32'h00000000);
    rd(sbr_pkg::SBR_OFF_RX_CTL, 32'h00000000);
    rd(sbr_pkg::SBR_OFF_DIV_LO, 32'h00000000);
    rd(sbr_pkg::SBR_OFF_DIV_HI, 32'h00000000);
    rd(sbr_pkg::SBR_OFF_TX_CTL, 32'h00000000);
    check({hresp, sync_mode, high_speed_select, baud_tick}, 32'h0);
    wr(sbr_pkg::SBR_OFF_DIV_LO, 32'hffffffa5);
    rd(sbr_pkg::SBR_OFF_DIV_LO, 32'h000000a5);
    wr(sbr_pkg::SBR_OFF_DIV_HI, 32'h0000005a);
    rd(sbr_pkg::SBR_OFF_DIV_HI, 32'h0000005a);
    wr(sbr_pkg::SBR_OFF_BAUD_CTL, 32'h000000ff);
    rx_idle <= 1'b1;
    abd_overflow <= 1'b1;
    rd(sbr_pkg::SBR_OFF_BAUD_CTL, 32'h000000db);
    check(baud_control, 8'h1b);
    check(wide_divisor_select, 1'b1);
    wr(sbr_pkg::SBR_OFF_TX_CTL, 32'h000000ff);
    tx_shift_empty <= 1'b1;
    rd(sbr_pkg::SBR_OFF_TX_CTL, 32'h000000ff);
    check({sync_mode, high_speed_select, transmit_status_control}, {2'b11, 8'hfd});
    wr(sbr_pkg::SBR_OFF_RX_CTL, 32'h000000ff);
    rx_frame_err <= 1'b1;
    rd(sbr_pkg::SBR_OFF_RX_CTL, 32'h000000fd);
    check(receive_status_control, 8'hf9);
    rd(8'h20, 32'h00000000);
    // High byte set in 8-bit modes, except the all-zero divisor case, to show that it is ignored there
    run_case(1'b0, 1'b0, 1'b0, 8'h01, 8'h02);
    run_case(1'b0, 1'b1, 1'b0, 8'h01, 8'h02);
    run_case(1'b0, 1'b0, 1'b1, 8'h01, 8'h01);
    run_case(1'b0, 1'b1, 1'b1, 8'h01, 8'h01);
    run_case(1'b1, 1'b0, 1'b0, 8'h01, 8'h02);
    run_case(1'b1, 1'b1, 1'b0, 8'h01, 8'h02);
    run_case(1'b1, 1'b1, 1'b1, 8'h01, 8'h01);
    run_case(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
    run_case(1'b1, 1'b0, 1'b1, 8'h01, 8'h01);
    // Leave non-reset values behind so the mid-run reset has work to do
    wr(sbr_pkg::SBR_OFF_BAUD_CTL, 32'h00000008);
    wr(sbr_pkg::SBR_OFF_DIV_LO, 32'h00000033);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(sbr_pkg::SBR_OFF_DIV_LO, 32'h00000000);
    check(wide_divisor_select, 1'b0);
    wrap_up();
  end
endmodule : sbr_baud_gen_test
